// file: pss_pkg.sv
// Purpose: Shared constants for the status summary register bank.
// Assumes: Registers are 16 bits wide, one per aligned 32-bit Wishbone word.
// Notes: Byte address is four times the register index.
package pss_pkg;
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int REG_W = 16;
	localparam int IDX_W = 6;
	localparam int IDX_LSB = 2;
	localparam int CNT_W = 16;
	localparam int IRQ_W = 6;
	localparam int FLAG_N = 4;

	// Register indices.
	localparam logic [IDX_W-1:0] IDX_BASIC_STATUS = 6'h01;
	localparam logic [IDX_W-1:0] IDX_AUTONEG_EXP = 6'h06;
	localparam logic [IDX_W-1:0] IDX_STATUS_SUMMARY = 6'h10;
	localparam logic [IDX_W-1:0] IDX_INT_STATUS_EVENT = 6'h12;
	localparam logic [IDX_W-1:0] IDX_FALSE_CARRIER_CNT = 6'h14;
	localparam logic [IDX_W-1:0] IDX_RX_ERROR_CNT = 6'h15;
	localparam logic [IDX_W-1:0] IDX_PHY_CONTROL = 6'h19;
	localparam logic [IDX_W-1:0] IDX_TENBASE_STATUS = 6'h1A;
	localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
	localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 6'h21;

	// Status summary field positions.
	localparam int SUM_RESERVED = 15;
	localparam int SUM_CROSSOVER = 14;
	localparam int SUM_RX_ERROR = 13;
	localparam int SUM_POLARITY = 12;
	localparam int SUM_FALSE_CARRIER = 11;
	localparam int SUM_SIGNAL_DETECT = 10;
	localparam int SUM_DESCR_LOCK = 9;
	localparam int SUM_PAGE_RX = 8;
	localparam int SUM_INT_PENDING = 7;
	localparam int SUM_REMOTE_FAULT = 6;

	// Positions in the neighbouring registers.
	localparam int TEN_POLARITY = 4;
	localparam int EXP_PAGE_RX = 1;
	localparam int BASIC_REMOTE_FAULT = 4;
	localparam int INT_PENDING_BIT = 0;
	localparam int CTRL_AUTO_ENABLE = 15;
	localparam int CTRL_FORCE = 14;

	// Sticky flag slots and interrupt status bits.
	localparam int FLAG_POLARITY = 0;
	localparam int FLAG_PAGE_RX = 1;
	localparam int FLAG_INT_PEND = 2;
	localparam int FLAG_REMOTE_FAULT = 3;
	localparam int IRQ_RX_ERROR = 0;
	localparam int IRQ_FALSE_CARRIER = 1;
	localparam int IRQ_PAGE_RX = 2;
	localparam int IRQ_REMOTE_FAULT = 3;
	localparam int IRQ_SIGNAL_LOST = 4;
	localparam int IRQ_LOCK_LOST = 5;

	// Reset values and counter constants.
	localparam logic CTRL_AUTO_ENABLE_RST = 1'h0;
	localparam logic CTRL_FORCE_RST = 1'h0;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 6'h00;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
endpackage : pss_pkg

// file: pss_sticky.sv
// Purpose: Sticky flag set by a hardware event and cleared by a pulse.
// Assumes: Both inputs come from logic on clk.
// Notes: A set in the clearing cycle wins, so no event is lost.
`timescale 1ns/100ps
`default_nettype none
module pss_sticky (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setPulse,
	input wire logic clearPulse,
	output logic flag
);
	typedef struct packed {
		logic flag;
	} pss_sticky_s;

	pss_sticky_s s;
	pss_sticky_s next_s;

	always_comb begin
		next_s = s;
		next_s.flag = setPulse | (s.flag & ~clearPulse);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign flag = s.flag;
endmodule : pss_sticky
`default_nettype wire

// file: pss_event_counter.sv
// Purpose: Saturating event counter with a seen latch, both cleared on read.
// Assumes: Events are one-cycle pulses on clk.
// Notes: An event in the read cycle counts one in the fresh window.
`timescale 1ns/100ps
`default_nettype none
module pss_event_counter (
	input wire logic clk,
	input wire logic rstn,
	input wire logic eventPulse,
	input wire logic readClear,
	output logic [pss_pkg::CNT_W-1:0] count,
	output logic seen
);
	typedef struct packed {
		logic [pss_pkg::CNT_W-1:0] count;
		logic seen;
	} pss_counter_s;

	pss_counter_s s;
	pss_counter_s next_s;

	always_comb begin
		next_s = s;
		if (readClear) begin
			next_s.count = eventPulse ? pss_pkg::CNT_ONE : '0;
			next_s.seen = eventPulse;
		end else if (eventPulse) begin
			// Saturation keeps a busy line from wrapping to a small count.
			if (s.count != pss_pkg::CNT_MAX) begin
				next_s.count = s.count + pss_pkg::CNT_ONE;
			end
			next_s.seen = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.count;
	assign seen = s.seen;
endmodule : pss_event_counter
`default_nettype wire

// file: pss_top.sv
// Purpose: Bits 15 down to 6 of the transceiver status summary register on Wishbone.
// Assumes: All status sources are synchronous to clk; events are one-cycle pulses.
// Notes: Bits 5 down to 0 of the summary read as zero here.
//
// Summary of operation
// R1 - Summary bit 15 ignores writes and always reads zero.
// R2 - Crossover bit depends on auto-enable and force bits in the control register.
// R3 - With auto enabled and not forced, crossover bit follows the algorithm live.
// R4 - Crossover bit reads 1 for swapped pairs, 0 for normal pairs.
// R5 - Receive error latch sets on any error, cleared by reading its counter.
// R6 - Polarity bit mirrors inverted polarity, cleared only by reading 10BASE-T status.
// R7 - False carrier latch sets on event, cleared by reading its counter.
// R8 - Signal detect bit latches low until the summary is read.
// R9 - Descrambler lock bit latches low until the summary is read.
// R10 - Page received bit copies expansion flag, cleared only by reading that register.
// R11 - Interrupt pending bit reads 1 until interrupt status register read clears it.
// R12 - Remote fault bit sets on partner fault, cleared by basic status read or reset.
// R13 - Summary bits 15 down to 6 reset to zero and ignore writes.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module pss_top (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [pss_pkg::ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [pss_pkg::DAT_W-1:0] wbDatIn,
	output logic [pss_pkg::DAT_W-1:0] wbDatOut,
	output logic wbAck,
	output logic irq,
	input wire logic crossoverSwapped,
	input wire logic rxErrorEvent,
	input wire logic falseCarrierEvent,
	input wire logic polarityInvertedEvent,
	input wire logic pageReceivedEvent,
	input wire logic interruptEvent,
	input wire logic remoteFaultEvent,
	input wire logic signalDetect,
	input wire logic descramblerLock,
	output logic crossoverAutoEnable,
	output logic crossoverForce
);
	typedef struct packed {
		logic ack;
		logic [pss_pkg::DAT_W-1:0] rdata;
		logic autoEnable;
		logic forceXover;
		logic crossover;
		logic signalDetect;
		logic descrLock;
		logic prevSignal;
		logic prevLock;
		logic [pss_pkg::IRQ_W-1:0] irqStatus;
		logic [pss_pkg::IRQ_W-1:0] irqMask;
		logic irq;
	} pss_top_s;

	pss_top_s s;
	pss_top_s next_s;

	// Byte lanes that carry the writable fields of the control and interrupt words.
	localparam int LANE_CTRL = 1;
	localparam int LANE_IRQ = 0;

	logic req;
	logic rdReq;
	logic wrReq;
	logic [pss_pkg::IDX_W-1:0] idx;
	logic clrBasic;
	logic clrExpansion;
	logic clrIntStatus;
	logic clrFalseCarrier;
	logic clrRxError;
	logic clrTenbase;
	logic rdSummary;
	logic rxErrorSeen;
	logic falseCarrierSeen;
	logic [pss_pkg::CNT_W-1:0] rxErrorCount;
	logic [pss_pkg::CNT_W-1:0] falseCarrierCount;
	logic [pss_pkg::FLAG_N-1:0] flagSet;
	logic [pss_pkg::FLAG_N-1:0] flagClear;
	logic [pss_pkg::FLAG_N-1:0] flag;
	logic [pss_pkg::REG_W-1:0] summary;
	logic [pss_pkg::IRQ_W-1:0] irqEvents;
	logic signalFell;
	logic lockFell;

	// Read decode is shared by every clear-on-read source.
	function automatic logic readHit(
		input logic rd,
		input logic [pss_pkg::IDX_W-1:0] at,
		input logic [pss_pkg::IDX_W-1:0] target
	);
		readHit = rd && (at == target);
	endfunction : readHit

	// Widens a 16-bit register to the bus word with zeros above.
	function automatic logic [pss_pkg::DAT_W-1:0] toWord(
		input logic [pss_pkg::REG_W-1:0] value
	);
		toWord = {{(pss_pkg::DAT_W - pss_pkg::REG_W){1'b0}}, value};
	endfunction : toWord

	// Places one status bit at its position in an otherwise empty bus word.
	function automatic logic [pss_pkg::DAT_W-1:0] bitWord(
		input int pos,
		input logic value
	);
		bitWord = {{(pss_pkg::DAT_W - 1){1'b0}}, value} << pos;
	endfunction : bitWord

	assign req = wbCyc & wbStb & ~s.ack;
	assign rdReq = req & ~wbWe;
	assign wrReq = req & wbWe;
	assign idx = wbAdr[pss_pkg::IDX_LSB +: pss_pkg::IDX_W];

	assign clrBasic = readHit(rdReq, idx, pss_pkg::IDX_BASIC_STATUS);
	assign clrExpansion = readHit(rdReq, idx, pss_pkg::IDX_AUTONEG_EXP);
	assign clrIntStatus = readHit(rdReq, idx, pss_pkg::IDX_INT_STATUS_EVENT);
	assign clrFalseCarrier = readHit(rdReq, idx, pss_pkg::IDX_FALSE_CARRIER_CNT);
	assign clrRxError = readHit(rdReq, idx, pss_pkg::IDX_RX_ERROR_CNT);
	assign clrTenbase = readHit(rdReq, idx, pss_pkg::IDX_TENBASE_STATUS);
	assign rdSummary = readHit(rdReq, idx, pss_pkg::IDX_STATUS_SUMMARY);

	// The previous levels reset low, so no false fall is seen just after reset.
	assign signalFell = s.prevSignal & ~signalDetect;
	assign lockFell = s.prevLock & ~descramblerLock;

	pss_event_counter uRxError (
		.clk(clk),
		.rstn(rstn),
		.eventPulse(rxErrorEvent),
		.readClear(clrRxError), // R5
		.count(rxErrorCount),
		.seen(rxErrorSeen)
	);

	pss_event_counter uFalseCarrier (
		.clk(clk),
		.rstn(rstn),
		.eventPulse(falseCarrierEvent),
		.readClear(clrFalseCarrier), // R7
		.count(falseCarrierCount),
		.seen(falseCarrierSeen)
	);

	// Each mirrored flag is cleared by its owning register, never by the summary.
	assign flagSet[pss_pkg::FLAG_POLARITY] = polarityInvertedEvent;
	assign flagClear[pss_pkg::FLAG_POLARITY] = clrTenbase; // R6
	assign flagSet[pss_pkg::FLAG_PAGE_RX] = pageReceivedEvent;
	assign flagClear[pss_pkg::FLAG_PAGE_RX] = clrExpansion; // R10
	assign flagSet[pss_pkg::FLAG_INT_PEND] = interruptEvent;
	assign flagClear[pss_pkg::FLAG_INT_PEND] = clrIntStatus; // R11
	assign flagSet[pss_pkg::FLAG_REMOTE_FAULT] = remoteFaultEvent;
	assign flagClear[pss_pkg::FLAG_REMOTE_FAULT] = clrBasic; // R12

	genvar gi;
	generate
		for (gi = 0; gi < pss_pkg::FLAG_N; gi++) begin : gFlag
			pss_sticky uFlag (
				.clk(clk),
				.rstn(rstn),
				.setPulse(flagSet[gi]),
				.clearPulse(flagClear[gi]),
				.flag(flag[gi])
			);
		end
	endgenerate

	always_comb begin
		summary = '0;
		summary[pss_pkg::SUM_RESERVED] = 1'b0; // R1
		summary[pss_pkg::SUM_CROSSOVER] = s.crossover; // R4
		summary[pss_pkg::SUM_RX_ERROR] = rxErrorSeen; // R5
		summary[pss_pkg::SUM_POLARITY] = flag[pss_pkg::FLAG_POLARITY]; // R6
		summary[pss_pkg::SUM_FALSE_CARRIER] = falseCarrierSeen; // R7
		summary[pss_pkg::SUM_SIGNAL_DETECT] = s.signalDetect; // R8
		summary[pss_pkg::SUM_DESCR_LOCK] = s.descrLock; // R9
		summary[pss_pkg::SUM_PAGE_RX] = flag[pss_pkg::FLAG_PAGE_RX]; // R10
		summary[pss_pkg::SUM_INT_PENDING] = flag[pss_pkg::FLAG_INT_PEND]; // R11
		summary[pss_pkg::SUM_REMOTE_FAULT] = flag[pss_pkg::FLAG_REMOTE_FAULT]; // R12
	end

	always_comb begin
		irqEvents = '0;
		irqEvents[pss_pkg::IRQ_RX_ERROR] = rxErrorEvent;
		irqEvents[pss_pkg::IRQ_FALSE_CARRIER] = falseCarrierEvent;
		irqEvents[pss_pkg::IRQ_PAGE_RX] = pageReceivedEvent;
		irqEvents[pss_pkg::IRQ_REMOTE_FAULT] = remoteFaultEvent;
		irqEvents[pss_pkg::IRQ_SIGNAL_LOST] = signalFell;
		irqEvents[pss_pkg::IRQ_LOCK_LOST] = lockFell;
	end

	always_comb begin
		next_s = s;
		next_s.ack = req;
		next_s.prevSignal = signalDetect;
		next_s.prevLock = descramblerLock;

		// Forcing overrides the algorithm; with neither bit the pairs stay normal.
		if (s.forceXover) begin
			next_s.crossover = 1'b1; // R2
		end else if (s.autoEnable) begin
			next_s.crossover = crossoverSwapped; // R3
		end else begin
			next_s.crossover = 1'b0; // R2
		end

		// A read reloads the live level; otherwise a low is held until then.
		if (rdSummary) begin
			next_s.signalDetect = signalDetect; // R8
			next_s.descrLock = descramblerLock; // R9
		end else begin
			next_s.signalDetect = s.signalDetect & signalDetect; // R8
			next_s.descrLock = s.descrLock & descramblerLock; // R9
		end

		// Read data is zero outside the acknowledge cycle, so a stale word never lingers.
		next_s.rdata = '0;
		if (rdReq) begin
			case (idx)
				pss_pkg::IDX_STATUS_SUMMARY: begin
					next_s.rdata = toWord(summary);
				end
				pss_pkg::IDX_BASIC_STATUS: begin
					next_s.rdata = bitWord(pss_pkg::BASIC_REMOTE_FAULT, flag[pss_pkg::FLAG_REMOTE_FAULT]);
				end
				pss_pkg::IDX_AUTONEG_EXP: begin
					next_s.rdata = bitWord(pss_pkg::EXP_PAGE_RX, flag[pss_pkg::FLAG_PAGE_RX]);
				end
				pss_pkg::IDX_INT_STATUS_EVENT: begin
					next_s.rdata = bitWord(pss_pkg::INT_PENDING_BIT, flag[pss_pkg::FLAG_INT_PEND]);
				end
				pss_pkg::IDX_FALSE_CARRIER_CNT: begin
					next_s.rdata = toWord(falseCarrierCount);
				end
				pss_pkg::IDX_RX_ERROR_CNT: begin
					next_s.rdata = toWord(rxErrorCount);
				end
				pss_pkg::IDX_TENBASE_STATUS: begin
					next_s.rdata = bitWord(pss_pkg::TEN_POLARITY, flag[pss_pkg::FLAG_POLARITY]);
				end
				pss_pkg::IDX_PHY_CONTROL: begin
					next_s.rdata[pss_pkg::CTRL_AUTO_ENABLE] = s.autoEnable;
					next_s.rdata[pss_pkg::CTRL_FORCE] = s.forceXover;
				end
				pss_pkg::IDX_IRQ_STATUS: begin
					next_s.rdata[pss_pkg::IRQ_W-1:0] = s.irqStatus;
				end
				pss_pkg::IDX_IRQ_MASK: begin
					next_s.rdata[pss_pkg::IRQ_W-1:0] = s.irqMask;
				end
				default: begin
					next_s.rdata = '0;
				end
			endcase
		end

		// The summary and the other status words have no write path at all.
		next_s.irqStatus = irqEvents | s.irqStatus;
		if (wrReq) begin
			case (idx)
				pss_pkg::IDX_PHY_CONTROL: begin
					if (wbSel[LANE_CTRL]) begin
						next_s.autoEnable = wbDatIn[pss_pkg::CTRL_AUTO_ENABLE]; // R2
						next_s.forceXover = wbDatIn[pss_pkg::CTRL_FORCE]; // R2
					end
				end
				pss_pkg::IDX_IRQ_STATUS: begin
					if (wbSel[LANE_IRQ]) begin
						// A new event in the clearing cycle keeps its bit set.
						next_s.irqStatus = irqEvents |
							(s.irqStatus & ~wbDatIn[pss_pkg::IRQ_W-1:0]);
					end
				end
				pss_pkg::IDX_IRQ_MASK: begin
					if (wbSel[LANE_IRQ]) begin
						next_s.irqMask = wbDatIn[pss_pkg::IRQ_W-1:0];
					end
				end
				// Status words are read-only; a write only earns its acknowledge.
				pss_pkg::IDX_STATUS_SUMMARY: begin
					next_s.irqMask = s.irqMask; // R1
				end
				pss_pkg::IDX_BASIC_STATUS: begin
					next_s.irqMask = s.irqMask; // R13
				end
				pss_pkg::IDX_AUTONEG_EXP: begin
					next_s.irqMask = s.irqMask; // R13
				end
				pss_pkg::IDX_INT_STATUS_EVENT: begin
					next_s.irqMask = s.irqMask; // R13
				end
				pss_pkg::IDX_FALSE_CARRIER_CNT: begin
					next_s.irqMask = s.irqMask; // R13
				end
				pss_pkg::IDX_RX_ERROR_CNT: begin
					next_s.irqMask = s.irqMask; // R13
				end
				pss_pkg::IDX_TENBASE_STATUS: begin
					next_s.irqMask = s.irqMask; // R13
				end
				default: begin
					next_s.irqMask = s.irqMask; // R13
				end
			endcase
		end
		// The interrupt is registered from next values, so it moves with its status bit.
		next_s.irq = |(next_s.irqStatus & next_s.irqMask);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			// Every summary source restarts at zero, the latching-low bits included.
			s.ack <= 1'b0;
			s.rdata <= '0;
			s.autoEnable <= pss_pkg::CTRL_AUTO_ENABLE_RST;
			s.forceXover <= pss_pkg::CTRL_FORCE_RST;
			s.crossover <= 1'b0; // R13
			s.signalDetect <= 1'b0; // R13
			s.descrLock <= 1'b0; // R13
			s.prevSignal <= 1'b0;
			s.prevLock <= 1'b0;
			s.irqStatus <= '0;
			s.irqMask <= pss_pkg::IRQ_MASK_RST;
			s.irq <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// Every output is a register bit; no port is driven through logic.
	assign wbAck = s.ack;
	assign wbDatOut = s.rdata;
	assign irq = s.irq;
	assign crossoverAutoEnable = s.autoEnable;
	assign crossoverForce = s.forceXover;
endmodule : pss_top
`default_nettype wire

// file: pss_chk.sv
// Purpose: Concurrent checks on the ports of the status summary block.
// Assumes: One clock domain; the master keeps classic single Wishbone cycles.
// Notes: Flag checks look at the ack cycle of a summary read right after the cause.
`timescale 1ns/100ps
`default_nettype none
module pss_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wbCyc,
	input wire logic wbStb,
	input wire logic wbWe,
	input wire logic [pss_pkg::ADR_W-1:0] wbAdr,
	input wire logic [3:0] wbSel,
	input wire logic [pss_pkg::DAT_W-1:0] wbDatIn,
	input wire logic [pss_pkg::DAT_W-1:0] wbDatOut,
	input wire logic wbAck,
	input wire logic irq,
	input wire logic crossoverSwapped,
	input wire logic rxErrorEvent,
	input wire logic falseCarrierEvent,
	input wire logic polarityInvertedEvent,
	input wire logic pageReceivedEvent,
	input wire logic interruptEvent,
	input wire logic remoteFaultEvent,
	input wire logic signalDetect,
	input wire logic descramblerLock,
	input wire logic crossoverAutoEnable,
	input wire logic crossoverForce
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	sequence sumRead;
		wbCyc && wbStb && !wbAck && !wbWe && wbAdr[7:2] == pss_pkg::IDX_STATUS_SUMMARY;
	endsequence
	sequence autoLive;
		crossoverAutoEnable && !crossoverForce;
	endsequence
	sequence sumAck;
		wbAck && !wbWe && wbAdr[7:2] == pss_pkg::IDX_STATUS_SUMMARY;
	endsequence
	sequence ctrlAck;
		wbAck && wbWe && wbSel[1] && wbAdr[7:2] == pss_pkg::IDX_PHY_CONTROL;
	endsequence
	property flagShown(ev, pos);
		ev ##1 sumRead |=> wbDatOut[pos];
	endproperty
	property lowHeld(lvl, pos);
		!lvl ##1 sumRead |=> !wbDatOut[pos];
	endproperty
	chk_ack_follows: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
		else $error("ack missing after request");
	chk_ack_single: assert property (wbAck |=> !wbAck)
		else $error("ack longer than one cycle");
	chk_data_idle: assert property (!wbAck |-> wbDatOut == '0)
		else $error("read data outside ack cycle");
	chk_top_zero: assert property (sumAck |-> wbDatOut[31:15] == '0)
		else $error("reserved top bits not zero");
	chk_rxerr_shown: assert property (flagShown(rxErrorEvent, 13))
		else $error("receive error latch missing");
	chk_fcar_shown: assert property (flagShown(falseCarrierEvent, 11))
		else $error("false carrier latch missing");
	chk_pol_shown: assert property (flagShown(polarityInvertedEvent, 12))
		else $error("polarity flag missing");
	chk_page_shown: assert property (flagShown(pageReceivedEvent, 8))
		else $error("page received flag missing");
	chk_pend_shown: assert property (flagShown(interruptEvent, 7))
		else $error("interrupt pending flag missing");
	chk_fault_shown: assert property (flagShown(remoteFaultEvent, 6))
		else $error("remote fault flag missing");
	chk_detect_low: assert property (lowHeld(signalDetect, 10))
		else $error("signal detect low not latched");
	chk_lock_low: assert property (lowHeld(descramblerLock, 9))
		else $error("descrambler lock low not latched");
	chk_xover_forced: assert property (crossoverForce ##1 (sumRead and crossoverForce) |=> wbDatOut[14])
		else $error("forced crossover not shown");
	chk_xover_live: assert property (autoLive ##1 (sumRead and autoLive and $stable(crossoverSwapped))
		|=> wbDatOut[14] == $past(crossoverSwapped))
		else $error("crossover not following algorithm");
	chk_xover_off: assert property (!crossoverAutoEnable && !crossoverForce ##1
		(sumRead and !crossoverAutoEnable && !crossoverForce) |=> !wbDatOut[14])
		else $error("crossover set without enable");
	chk_ctrl_copy: assert property (ctrlAck |-> crossoverAutoEnable == wbDatIn[15]
		&& crossoverForce == wbDatIn[14])
		else $error("control outputs not updated");
endmodule : pss_chk
bind pss_top pss_chk u_chk (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
	.wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
	.irq(irq), .crossoverSwapped(crossoverSwapped), .rxErrorEvent(rxErrorEvent),
	.falseCarrierEvent(falseCarrierEvent), .polarityInvertedEvent(polarityInvertedEvent),
	.pageReceivedEvent(pageReceivedEvent), .interruptEvent(interruptEvent),
	.remoteFaultEvent(remoteFaultEvent), .signalDetect(signalDetect),
	.descramblerLock(descramblerLock), .crossoverAutoEnable(crossoverAutoEnable),
	.crossoverForce(crossoverForce));
`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench for the status summary register block.
// Assumes: The driver queues expected read words; a monitor compares at each read ack.
// Notes: Bits of neighbouring registers outside this block are masked in compares.
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {logic [31:0] val; logic [31:0] msk;} pss_exp_s;
	localparam logic [5:0] SUM = pss_pkg::IDX_STATUS_SUMMARY;
	localparam logic [31:0] ALL = 32'hFFFFFFFF;
	logic clk, rstn, wbCyc, wbStb, wbWe, wbAck, irq, xSwap, sigDet, lock, autoEn, forceX;
	logic [7:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatIn, wbDatOut;
	logic [5:0] evts, m;
	logic [3:0] cx [5] = '{4'hD, 4'h4, 4'hA, 4'hF, 4'h1};
	logic [5:0] oIdx [6] = '{6'h15, 6'h14, 6'h1A, 6'h06, 6'h12, 6'h01};
	int oPos [6] = '{0, 0, 4, 1, 0, 4};
	logic [31:0] oMsk [6] = '{32'hFFFF, 32'hFFFF, 32'h10, 32'h2, 32'h1, 32'h10};
	pss_exp_s expQ[$];
	int nFail = 0;
	int testsRun = 0;
	int cycles = 0;
	pss_top dut (.clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
		.wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
		.irq(irq), .crossoverSwapped(xSwap), .rxErrorEvent(evts[0]),
		.falseCarrierEvent(evts[1]), .polarityInvertedEvent(evts[2]),
		.pageReceivedEvent(evts[3]), .interruptEvent(evts[4]), .remoteFaultEvent(evts[5]),
		.signalDetect(sigDet), .descramblerLock(lock), .crossoverAutoEnable(autoEn),
		.crossoverForce(forceX));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", testsRun, nFail);
		if (nFail == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : complete_run
	task automatic cmp_word(input logic [31:0] got, input pss_exp_s x);
		testsRun++;
		if ((got & x.msk) !== (x.val & x.msk)) begin
			nFail++;
			$display("mismatch read data expected %h seen %h", x.val & x.msk, got & x.msk);
		end
	endtask : cmp_word
	task automatic cmp_bit(input logic got, input logic x);
		testsRun++;
		if (got !== x) begin
			nFail++;
			$display("mismatch irq expected %b seen %b", x, got);
		end
	endtask : cmp_bit
	// Reads queue the expected word; the request is held until ack is sampled.
	task automatic bus(input logic we, input logic [5:0] idx, input logic [31:0] d,
		input logic [31:0] msk);
		@(posedge clk);
		evts <= 6'h00;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= {idx, 2'h0};
		wbSel <= 4'hF;
		wbDatIn <= we ? d : 32'($urandom);
		if (!we) expQ.push_back(pss_exp_s'{d, msk});
		do @(posedge clk); while (wbAck !== 1'b1);
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		wbWe <= 1'b0;
	endtask : bus
	function automatic logic [31:0] sum_exp(input logic [5:0] f);
		return 32'h0600 | {f[0], f[2], f[1], 2'h0, f[3], f[4], f[5], 6'h0};
	endfunction : sum_exp
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			nFail++;
			complete_run();
		end
		if (wbAck === 1'b1 && wbWe === 1'b0) begin
			if (expQ.size() > 0) cmp_word(wbDatOut, expQ.pop_front());
			else begin
				nFail++;
				$display("mismatch read queue expected entry seen none");
			end
		end
	end
	initial begin
		rstn = 1'b0;
		{wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatIn, xSwap, evts} = '0;
		sigDet = 1'b1;
		lock = 1'b1;
		void'($urandom(32'h4C77));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		bus(1'b0, SUM, 32'h0, ALL);
		bus(1'b0, pss_pkg::IDX_IRQ_MASK, 32'h0, ALL);
		bus(1'b1, SUM, 32'hFFFF, ALL);
		bus(1'b0, SUM, 32'h0600, ALL);
		bus(1'b0, 6'h3F, 32'h0, ALL);
		@(posedge clk);
		sigDet <= 1'b0;
		lock <= 1'b0;
		bus(1'b0, SUM, 32'h0, 32'h0600);
		sigDet <= 1'b1;
		lock <= 1'b1;
		bus(1'b0, SUM, 32'h0, 32'h0600);
		bus(1'b0, SUM, 32'h0600, 32'h0600);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			xSwap <= cx[i][0];
			bus(1'b1, pss_pkg::IDX_PHY_CONTROL, {16'h0, cx[i][2:1], 14'h0}, ALL);
			bus(1'b0, pss_pkg::IDX_PHY_CONTROL, {16'h0, cx[i][2:1], 14'h0}, 32'hC000);
			bus(1'b0, SUM, {17'h0, cx[i][3], 14'h0}, 32'h4000);
		end
		for (int i = 0; i < 3; i++) begin
			m = (i == 0) ? 6'h3F : 6'($urandom);
			@(posedge clk);
			evts <= m;
			bus(1'b0, SUM, sum_exp(m), 32'h7FC0);
			bus(1'b0, SUM, sum_exp(m), 32'h7FC0);
			for (int j = 0; j < 6; j++) bus(1'b0, oIdx[j], 32'(m[j]) << oPos[j], oMsk[j]);
			bus(1'b0, SUM, 32'h0600, 32'h7FC0);
		end
		bus(1'b1, pss_pkg::IDX_IRQ_STATUS, 32'h3F, ALL);
		bus(1'b0, pss_pkg::IDX_IRQ_STATUS, 32'h0, 32'h3F);
		@(posedge clk);
		evts <= 6'h01;
		bus(1'b0, pss_pkg::IDX_IRQ_STATUS, 32'h1, 32'h3F);
		cmp_bit(irq, 1'b0);
		bus(1'b1, pss_pkg::IDX_IRQ_MASK, 32'h1, ALL);
		repeat (2) @(posedge clk);
		cmp_bit(irq, 1'b1);
		bus(1'b1, pss_pkg::IDX_IRQ_STATUS, 32'h1, ALL);
		repeat (2) @(posedge clk);
		cmp_bit(irq, 1'b0);
		complete_run();
	end
endmodule : tb
`default_nettype wire
